// ---- common/gpc_pkg.sv ----
package gpc_pkg;
  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_MAIN    = 8'h00;
  localparam logic [7:0] ADDR_SECOND  = 8'h04;
  localparam logic [7:0] ADDR_POS_OFS = 8'h08;
  localparam logic [7:0] ADDR_NEG_OFS = 8'h0c;
  localparam logic [7:0] ADDR_DELAY_A = 8'h10;
  localparam logic [7:0] ADDR_DELAY_B = 8'h14;
  localparam logic [7:0] ADDR_RESULT  = 8'h18;
  localparam logic [7:0] ADDR_STATUS  = 8'h1c;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int MAIN_CONV_EN  = 0;
  localparam int MAIN_START    = 1;
  localparam int MAIN_REG_EN   = 2;
  localparam int MAIN_MUTE     = 3;
  localparam int MAIN_CHAN_LSB = 4;
  localparam int SEC_ATTN      = 0;
  localparam int SEC_DLY_EN    = 1;
  localparam int DLY_LO_LSB    = 0;
  localparam int DLY_HI_LSB    = 16;
  localparam int STAT_BUSY     = 0;
  localparam int STAT_CNT_RUN  = 1;
  localparam int STAT_CNT_USED = 2;
  localparam int STAT_CNT_LSB  = 16;
  // ------------------------------------------------------------
  // widths, battery channel code and reset values
  // ------------------------------------------------------------
  localparam int DLY_W  = 13;
  localparam int CHAN_W = 4;
  localparam int RES_W  = 10;
  localparam logic [CHAN_W-1:0] CHAN_BATTERY = 4'h4;
  localparam logic [RES_W-1:0]  OFS_RESET    = 10'h200;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int T_CONV_PS      = 62500;
  localparam int T_DELAY_MAX_NS = 32000;
  localparam int T_REG_SETTLE_NS = 20000;
  localparam int T_ATTN_SETTLE_NS = 1000;
  localparam int CONV_CYC = T_CONV_PS / CLK_PERIOD_PS;
  localparam int DELAY_MAX_CYC = (T_DELAY_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int REG_SETTLE_CYC = (T_REG_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ATTN_SETTLE_CYC = (T_ATTN_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [DLY_W-1:0] DLY_REG_RESET   = 13'h0000;
  localparam logic [DLY_W-1:0] DLY_EN_RESET    = DLY_W'(REG_SETTLE_CYC);
  localparam logic [DLY_W-1:0] DLY_START_RESET = DLY_W'(REG_SETTLE_CYC + ATTN_SETTLE_CYC);
  // ------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} gpc_state_t;
endpackage

// ---- rtl/gpc_delay_gate.sv ----
`timescale 1ns/1ps
module gpc_delay_gate #(
  parameter int W = 13
) (
  input  wire logic         ctrl,
  input  wire logic         bypass,
  input  wire logic [W-1:0] count,
  input  wire logic [W-1:0] setting,
  output logic              gated
);
  // control passes once its programmed delay has elapsed
  assign gated = ctrl & (bypass | (count >= setting));
endmodule

// ---- rtl/gpc_converter_ctrl.sv ----
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module gpc_converter_ctrl #(
  parameter int DELAY_MAX = gpc_pkg::DELAY_MAX_CYC
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic [9:0]  adc_data,
  output logic             adc_regulator_en,
  output logic             adc_enable,
  output logic             adc_convert,
  output logic             adc_mute,
  output logic             adc_attn,
  output logic      [3:0]  adc_channel,
  output logic      [9:0]  adc_offset_pos,
  output logic      [9:0]  adc_offset_neg
);
  localparam int DW = gpc_pkg::DLY_W;

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  logic          conv_en, start, reg_en, mute, attn_bit, dly_en;
  logic [3:0]    chan;
  logic [9:0]    pos_ofs, neg_ofs, result;
  logic [DW-1:0] dly_reg, dly_en_set, dly_start;
  logic [DW-1:0] cnt;
  logic          cnt_run, cnt_used;
  logic [3:0]    conv_cnt;
  gpc_pkg::gpc_state_t state, next_state;

  wire wr_main   = wr && addr == gpc_pkg::ADDR_MAIN;
  wire wr_second = wr && addr == gpc_pkg::ADDR_SECOND;
  wire wr_pos    = wr && addr == gpc_pkg::ADDR_POS_OFS;
  wire wr_neg    = wr && addr == gpc_pkg::ADDR_NEG_OFS;
  wire wr_dly_a  = wr && addr == gpc_pkg::ADDR_DELAY_A;
  wire wr_dly_b  = wr && addr == gpc_pkg::ADDR_DELAY_B;
  wire start_set = wr_main && wdata[gpc_pkg::MAIN_START];
  wire conv_done = state == gpc_pkg::ST_CONV && conv_cnt == 4'(gpc_pkg::CONV_CYC - 1);
  wire next_start = start_set | (start & ~conv_done);
  wire battery   = chan == gpc_pkg::CHAN_BATTERY;
  wire attn_eff  = attn_bit | battery;
  wire cnt_go    = start_set && dly_en && !cnt_run && !cnt_used;

  always_ff @(posedge clk) begin
    if (srst) begin
      conv_en    <= 1'b0;
      start      <= 1'b0;
      reg_en     <= 1'b0;
      mute       <= 1'b0;
      chan       <= 4'h0;
      attn_bit   <= 1'b0;
      dly_en     <= 1'b0;
      pos_ofs    <= gpc_pkg::OFS_RESET;
      neg_ofs    <= gpc_pkg::OFS_RESET;
      dly_reg    <= gpc_pkg::DLY_REG_RESET;
      dly_en_set <= gpc_pkg::DLY_EN_RESET;
      dly_start  <= gpc_pkg::DLY_START_RESET;
    end else begin
      start <= next_start;
      if (wr_main) begin
        conv_en <= wdata[gpc_pkg::MAIN_CONV_EN];
        reg_en  <= wdata[gpc_pkg::MAIN_REG_EN];
        mute    <= wdata[gpc_pkg::MAIN_MUTE];
        chan    <= wdata[gpc_pkg::MAIN_CHAN_LSB +: 4];
      end
      if (wr_second) begin
        attn_bit <= wdata[gpc_pkg::SEC_ATTN];
        dly_en   <= wdata[gpc_pkg::SEC_DLY_EN];
      end
      if (wr_pos) pos_ofs <= wdata[9:0];
      if (wr_neg) neg_ofs <= wdata[9:0];
      if (wr_dly_a) begin
        dly_reg    <= wdata[gpc_pkg::DLY_LO_LSB +: DW];
        dly_en_set <= wdata[gpc_pkg::DLY_HI_LSB +: DW];
      end
      if (wr_dly_b) dly_start <= wdata[gpc_pkg::DLY_LO_LSB +: DW];
    end
  end

  // ------------------------------------------------------------
  // delay counter
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || !dly_en) begin
      cnt      <= '0;
      cnt_run  <= 1'b0;
      cnt_used <= 1'b0;
    end else begin
      if (cnt_go) cnt_run <= 1'b1;
      else if (cnt_run && conv_done) begin
        cnt_run  <= 1'b0;
        cnt_used <= 1'b1;
      end
      if (cnt_run && cnt < DW'(DELAY_MAX)) cnt <= cnt + 1'b1;
    end
  end

  logic reg_gated, en_gated, start_gated;
  wire  bypass = ~dly_en;

  gpc_delay_gate #(.W(DW)) u_gate_reg (
    .ctrl(reg_en), .bypass(bypass), .count(cnt), .setting(dly_reg), .gated(reg_gated));
  gpc_delay_gate #(.W(DW)) u_gate_en (
    .ctrl(conv_en), .bypass(bypass), .count(cnt), .setting(dly_en_set), .gated(en_gated));
  gpc_delay_gate #(.W(DW)) u_gate_start (
    .ctrl(start), .bypass(bypass), .count(cnt), .setting(dly_start),
    .gated(start_gated));

  // ------------------------------------------------------------
  // conversion sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      gpc_pkg::ST_IDLE: if (start) next_state = gpc_pkg::ST_WAIT;
      gpc_pkg::ST_WAIT: if (start_gated) next_state = gpc_pkg::ST_CONV;
      gpc_pkg::ST_CONV: if (conv_done) next_state = gpc_pkg::ST_IDLE;
      default:          next_state = gpc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state    <= gpc_pkg::ST_IDLE;
      conv_cnt <= 4'h0;
      result   <= 10'h000;
    end else begin
      state    <= next_state;
      conv_cnt <= (state == gpc_pkg::ST_CONV) ? conv_cnt + 1'b1 : 4'h0;
      if (conv_done) result <= adc_data;
    end
  end

  // ------------------------------------------------------------
  // converter outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      adc_regulator_en <= 1'b0;
      adc_enable       <= 1'b0;
      adc_mute         <= 1'b0;
      adc_attn         <= 1'b0;
      adc_channel      <= 4'h0;
      adc_offset_pos   <= gpc_pkg::OFS_RESET;
      adc_offset_neg   <= gpc_pkg::OFS_RESET;
    end else begin
      adc_regulator_en <= reg_gated;
      adc_enable       <= en_gated;
      adc_mute         <= mute;
      adc_attn         <= attn_eff;
      adc_channel      <= chan;
      adc_offset_pos   <= pos_ofs;
      adc_offset_neg   <= neg_ofs;
    end
  end
  assign adc_convert = state == gpc_pkg::ST_CONV;

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (addr)
      gpc_pkg::ADDR_MAIN: begin
        rd_mux[gpc_pkg::MAIN_CONV_EN]       = conv_en;
        rd_mux[gpc_pkg::MAIN_START]         = start;
        rd_mux[gpc_pkg::MAIN_REG_EN]        = reg_en;
        rd_mux[gpc_pkg::MAIN_MUTE]          = mute;
        rd_mux[gpc_pkg::MAIN_CHAN_LSB +: 4] = chan;
      end
      gpc_pkg::ADDR_SECOND: begin
        rd_mux[gpc_pkg::SEC_ATTN]   = attn_eff;
        rd_mux[gpc_pkg::SEC_DLY_EN] = dly_en;
      end
      gpc_pkg::ADDR_POS_OFS: rd_mux[9:0] = pos_ofs;
      gpc_pkg::ADDR_NEG_OFS: rd_mux[9:0] = neg_ofs;
      gpc_pkg::ADDR_DELAY_A: begin
        rd_mux[gpc_pkg::DLY_LO_LSB +: DW] = dly_reg;
        rd_mux[gpc_pkg::DLY_HI_LSB +: DW] = dly_en_set;
      end
      gpc_pkg::ADDR_DELAY_B: rd_mux[gpc_pkg::DLY_LO_LSB +: DW] = dly_start;
      gpc_pkg::ADDR_RESULT:  rd_mux[9:0] = result;
      gpc_pkg::ADDR_STATUS: begin
        rd_mux[gpc_pkg::STAT_BUSY]           = state != gpc_pkg::ST_IDLE;
        rd_mux[gpc_pkg::STAT_CNT_RUN]        = cnt_run;
        rd_mux[gpc_pkg::STAT_CNT_USED]       = cnt_used;
        rd_mux[gpc_pkg::STAT_CNT_LSB +: DW]  = cnt;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) rdata <= 32'h0000_0000;
    else      rdata <= rd ? rd_mux : 32'h0000_0000;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_offset_pos_follow: assert property (wr_pos |->
                                        ##2 adc_offset_pos == $past(wdata[9:0], 2))
    else $error("positive trim not applied");
  a_mute_follow: assert property (wr_main |-> ##2 adc_mute == $past(wdata[3], 2))
    else $error("mute not applied");
  a_battery_attn: assert property (battery |=> adc_attn)
    else $error("battery channel without attenuator");
  a_conv_length: assert property ($rose(adc_convert) |->
                                  adc_convert [*8] ##1 adc_convert [*4] ##1 !adc_convert)
    else $error("conversion length wrong");
  a_start_clear: assert property (conv_done && !start_set |=>
                                  !start && state == gpc_pkg::ST_IDLE)
    else $error("start bit not cleared");
  a_delay_hold: assert property (dly_en && state == gpc_pkg::ST_WAIT && cnt < dly_start
                                 |=> !adc_convert)
    else $error("conversion before start delay");
  a_no_restart: assert property (cnt_used && dly_en |=> !cnt_run && $stable(cnt))
    else $error("counter restarted");
  a_counter_clear: assert property (!dly_en |=> cnt == '0 && !cnt_run && !cnt_used)
    else $error("counter not reset");
  a_counter_start: assert property (cnt_go |=> cnt_run ##1 cnt == 13'h0001)
    else $error("counter not started");
  a_no_joint_rise: assert property (dly_en && dly_reg != dly_en_set
                                    |-> !($rose(reg_gated) && $rose(en_gated)))
    else $error("regulator and enable rose together");

  c_plain_conv: cover property (!dly_en && start_set ##[1:20] conv_done);
  c_delayed_conv: cover property (cnt_run && conv_done);
  c_battery: cover property (battery && adc_convert);
  c_set_wins: cover property (conv_done && start_set);
endmodule

// ---- sim/test_gpc_converter_ctrl.sv ----
`timescale 1ns/1ps
module test_gpc_converter_ctrl;
  logic        clk;
  logic        srst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [9:0]  adc_data;
  logic        adc_regulator_en;
  logic        adc_enable;
  logic        adc_convert;
  logic        adc_mute;
  logic        adc_attn;
  logic [3:0]  adc_channel;
  logic [9:0]  adc_offset_pos;
  logic [9:0]  adc_offset_neg;
  int          fail_count;
  int          n_tests;
  logic [31:0] d;

  gpc_converter_ctrl gpc_converter_ctrl_inst (
    .clk              (clk),
    .srst             (srst),
    .addr             (addr),
    .wdata            (wdata),
    .wr               (wr),
    .rd               (rd),
    .rdata            (rdata),
    .adc_data         (adc_data),
    .adc_regulator_en (adc_regulator_en),
    .adc_enable       (adc_enable),
    .adc_convert      (adc_convert),
    .adc_mute         (adc_mute),
    .adc_attn         (adc_attn),
    .adc_channel      (adc_channel),
    .adc_offset_pos   (adc_offset_pos),
    .adc_offset_neg   (adc_offset_neg)
  );

  always #2.5 clk = ~clk;

  // ------------------------------------------------------------
  // shared helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic settle();
    @(posedge clk);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic reset_values();
    rd_reg(gpc_pkg::ADDR_DELAY_A, d);
    check(d, {3'h0, gpc_pkg::DLY_EN_RESET, 3'h0, gpc_pkg::DLY_REG_RESET});
    rd_reg(gpc_pkg::ADDR_DELAY_B, d);
    check(d, {19'h0, gpc_pkg::DLY_START_RESET});
    check({22'h0, adc_offset_pos}, 32'h200);
    rd_reg(8'h20, d);
    check(d, 32'h0);
  endtask

  task automatic trims();
    wr_reg(gpc_pkg::ADDR_POS_OFS, 32'h300);
    wr_reg(gpc_pkg::ADDR_NEG_OFS, 32'h300);
    settle();
    check({22'h0, adc_offset_pos}, 32'h300);
    check({22'h0, adc_offset_neg}, 32'h300);
    wr_reg(gpc_pkg::ADDR_POS_OFS, 32'h2fd);
    wr_reg(gpc_pkg::ADDR_NEG_OFS, 32'h303);
    settle();
    check({22'h0, adc_offset_pos}, 32'h2fd);
    check({22'h0, adc_offset_neg}, 32'h303);
    rd_reg(gpc_pkg::ADDR_NEG_OFS, d);
    check(d, 32'h303);
  endtask

  task automatic plain_conversion();
    int n;
    n = 0;
    wr_reg(gpc_pkg::ADDR_MAIN, 32'h4);
    settle();
    check({31'h0, adc_regulator_en}, 32'h1);
    repeat (gpc_pkg::REG_SETTLE_CYC) @(posedge clk);
    adc_data <= 10'h2a5;
    wr_reg(gpc_pkg::ADDR_MAIN, 32'h7);
    for (int i = 0; i < 40; i++) begin
      settle();
      if (adc_convert === 1'b1) n++;
    end
    check(32'(n), 32'(gpc_pkg::CONV_CYC));
    rd_reg(gpc_pkg::ADDR_RESULT, d);
    check(d, 32'h2a5);
    rd_reg(gpc_pkg::ADDR_MAIN, d);
    check({31'h0, d[1]}, 32'h0);
  endtask

  task automatic mute_and_battery();
    int n;
    n = 0;
    wr_reg(gpc_pkg::ADDR_MAIN, 32'h4d);
    settle();
    check({31'h0, adc_mute}, 32'h1);
    check({31'h0, adc_attn}, 32'h1);
    rd_reg(gpc_pkg::ADDR_SECOND, d);
    check({31'h0, d[gpc_pkg::SEC_ATTN]}, 32'h1);
    repeat (gpc_pkg::ATTN_SETTLE_CYC) @(posedge clk);
    adc_data <= 10'h1ff;
    wr_reg(gpc_pkg::ADDR_MAIN, 32'h4f);
    for (int i = 0; i < 40; i++) begin
      settle();
      if (adc_convert === 1'b1 && adc_attn === 1'b1) n++;
    end
    check(32'(n), 32'(gpc_pkg::CONV_CYC));
    rd_reg(gpc_pkg::ADDR_RESULT, d);
    check(d, 32'h1ff);
    wr_reg(gpc_pkg::ADDR_MAIN, 32'h15);
    settle();
    check({28'h0, adc_channel}, 32'h1);
    check({31'h0, adc_attn}, 32'h0);
  endtask

  task automatic delayed_start();
    int          tr;
    int          te;
    int          tc;
    logic [12:0] frozen;
    tr = -1;
    te = -1;
    tc = -1;
    wr_reg(gpc_pkg::ADDR_MAIN, 32'h0);
    // regulator at 10, enable at 4010, start at 4220 counts
    wr_reg(gpc_pkg::ADDR_DELAY_A, 32'h0faa_000a);
    wr_reg(gpc_pkg::ADDR_DELAY_B, 32'h107c);
    rd_reg(gpc_pkg::ADDR_SECOND, d);
    check({31'h0, d[gpc_pkg::SEC_DLY_EN]}, 32'h0);
    wr_reg(gpc_pkg::ADDR_SECOND, 32'h2);
    wr_reg(gpc_pkg::ADDR_MAIN, 32'h7);
    for (int i = 0; i < 4300; i++) begin
      settle();
      if (tr < 0 && adc_regulator_en === 1'b1) tr = i;
      if (te < 0 && adc_enable === 1'b1) te = i;
      if (tc < 0 && adc_convert === 1'b1) tc = i;
    end
    check(32'(te - tr), 32'd4000);
    check(32'(tc - te), 32'd210);
    check({31'h0, tr >= 0 && tc - tr >= gpc_pkg::REG_SETTLE_CYC}, 32'h1);
    check({31'h0, tr >= 0 && tr < te && te < tc}, 32'h1);
    rd_reg(gpc_pkg::ADDR_STATUS, d);
    check({29'h0, d[2:0]}, 32'h4);
    frozen = d[28:16];
    wr_reg(gpc_pkg::ADDR_MAIN, 32'h7);
    repeat (20) settle();
    rd_reg(gpc_pkg::ADDR_STATUS, d);
    check({31'h0, d[1]}, 32'h0);
    check({19'h0, d[28:16]}, {19'h0, frozen});
    wr_reg(gpc_pkg::ADDR_SECOND, 32'h0);
    rd_reg(gpc_pkg::ADDR_STATUS, d);
    check({d[28:16], d[2:1]}, 15'h0);
  endtask

  task automatic reset_again();
    wr_reg(gpc_pkg::ADDR_POS_OFS, 32'h155);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    settle();
    check({22'h0, adc_offset_pos}, 32'h200);
    check({29'h0, adc_regulator_en, adc_enable, adc_convert}, 32'h0);
    rd_reg(gpc_pkg::ADDR_DELAY_B, d);
    check(d, {19'h0, gpc_pkg::DLY_START_RESET});
  endtask

  initial begin
    clk        = 1'b0;
    srst       = 1'b1;
    addr       = 8'h00;
    wdata      = 32'h0;
    wr         = 1'b0;
    rd         = 1'b0;
    adc_data   = 10'h000;
    fail_count = 0;
    n_tests    = 0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    reset_values();
    trims();
    plain_conversion();
    mute_and_battery();
    delayed_start();
    reset_again();
    tally_and_finish();
  end

  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end
endmodule
